// ### logic/psh_pkg.sv
// Package for the pin state hold block
package psh_pkg;
    localparam int unsigned PSH_NUM_PINS = 8;

    // Per-pin state selection codes
    localparam logic [1:0] PSH_SEL_LOW  = 2'h0;
    localparam logic [1:0] PSH_SEL_HIGH = 2'h1;
    localparam logic [1:0] PSH_SEL_HOLD = 2'h2;
    localparam logic [1:0] PSH_SEL_TRI  = 2'h3;

    // Cell vector layout {input, enable, output}
    localparam int unsigned PSH_CELL_IN  = 2;
    localparam int unsigned PSH_CELL_OE  = 1;
    localparam int unsigned PSH_CELL_OUT = 0;

    // Decoded cell values per selection
    localparam logic [2:0] PSH_CELLS_TRI  = 3'h4;
    localparam logic [2:0] PSH_CELLS_LOW  = 3'h6;
    localparam logic [2:0] PSH_CELLS_HIGH = 3'h3;

    // Reset values of the cells and pins
    localparam logic [2:0] PSH_CELLS_RST = 3'h4;
    localparam logic       PSH_PIN_RST   = 1'h0;

    // Register bus
    localparam int unsigned PSH_AW = 4;
    localparam logic [3:0] PSH_OFS_CTRL  = 4'h0;
    localparam logic [3:0] PSH_OFS_SEL   = 4'h1;
    localparam logic [3:0] PSH_OFS_IN    = 4'h2;
    localparam logic [3:0] PSH_OFS_OE    = 4'h3;
    localparam logic [3:0] PSH_OFS_OUT   = 4'h4;
    localparam logic [3:0] PSH_OFS_STAT  = 4'h5;
    localparam logic [3:0] PSH_OFS_LAST  = 4'h6;
    localparam int unsigned PSH_CTRL_MODE = 0;

    typedef enum logic [2:0] {
        PSH_ST_FUNC  = 3'b001,
        PSH_ST_HOLD  = 3'b010,
        PSH_ST_APPLY = 3'b100
    } psh_state_t;
endpackage

// ### logic/psh_top.sv
// Pin state hold logic used while the device is being programmed
//
// Notes on behaviour
// RL1 - Each pin has an input cell, an output cell and an enable cell.
// RL2 - Selected state is applied on programming entry and held throughout.
// RL3 - Selection offers drive high, drive low, hold last level, tristate.
// RL4 - Simple mode decode: tri 1/0/0, low 1/1/0, high 0/1/1 (in/oe/out).
// RL5 - Hold choice captures last driven level into input and output cells; enable cell is set to 1.
// RL6 - Enable cell at 0 tristates the pin regardless of other cells.
// RL7 - Enable cell at 1 drives the output cell; input cell is ignored.
// RL8 - Changing a don't-care cell leaves the pin state unchanged.
// RL9 - Per-cell override mode loads each cell of each pin directly.
// RL10 - Simple mode guarantees only the pin output state.
// RL11 - Per-cell values take effect as the device leaves programming. The code also loads them on programming entry.
// RL12 - Outside programming the pins follow normal functional logic.
module psh_top #(
    parameter int unsigned NUM_PINS = psh_pkg::PSH_NUM_PINS
) (
    input  wire logic                       ref_clk_i,
    input  wire logic                       rstn_i,
    input  wire logic                       prog_mode_i,
    input  wire logic [NUM_PINS-1:0]        func_out_i,
    input  wire logic [NUM_PINS-1:0]        func_oe_i,
    input  wire logic [NUM_PINS-1:0]        pad_in_i,
    input  wire logic [psh_pkg::PSH_AW-1:0] reg_addr_i,
    input  wire logic [31:0]                reg_wdata_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    output logic      [31:0]                reg_rdata_o,
    output logic      [NUM_PINS-1:0]        pad_out_o,
    output logic      [NUM_PINS-1:0]        pad_oe_o,
    output logic      [NUM_PINS-1:0]        pad_in_o,
    output logic                            holding_o
);
    import psh_pkg::*;

    // Decode of one selection into {in, oe, out}
    function automatic logic [2:0] sel_cells(input logic [1:0] s, input logic lv);
        logic [2:0] c;
        c = PSH_CELLS_TRI;
        case (s)
            PSH_SEL_LOW:  c = PSH_CELLS_LOW;
            PSH_SEL_HIGH: c = PSH_CELLS_HIGH;
            PSH_SEL_HOLD: c = {lv, 1'b1, lv};
            default:      c = PSH_CELLS_TRI;
        endcase
        return c;
    endfunction

    // Synchronisers for the pin side inputs
    logic                prog_s1_q;
    logic                prog_s2_q;
    logic [NUM_PINS-1:0] pin_s1_q;
    logic [NUM_PINS-1:0] pin_s2_q;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            prog_s1_q <= 1'b0;
            prog_s2_q <= 1'b0;
            pin_s1_q  <= '0;
            pin_s2_q  <= '0;
        end else begin
            prog_s1_q <= prog_mode_i;
            prog_s2_q <= prog_s1_q;
            pin_s1_q  <= pad_in_i;
            pin_s2_q  <= pin_s1_q;
        end
    end

    // Configuration registers
    logic                  mode_q;
    logic [2*NUM_PINS-1:0] sel_q;
    logic [NUM_PINS-1:0]   ovr_in_q;
    logic [NUM_PINS-1:0]   ovr_oe_q;
    logic [NUM_PINS-1:0]   ovr_out_q;

    // Hold state registers
    psh_state_t          state_q;
    psh_state_t          state_d;
    logic [NUM_PINS-1:0] last_q;
    logic [NUM_PINS-1:0] cell_in_q;
    logic [NUM_PINS-1:0] cell_oe_q;
    logic [NUM_PINS-1:0] cell_out_q;

    wire wr_ctrl = reg_wr_i && (reg_addr_i == PSH_OFS_CTRL);
    wire wr_sel  = reg_wr_i && (reg_addr_i == PSH_OFS_SEL);
    wire wr_in   = reg_wr_i && (reg_addr_i == PSH_OFS_IN);
    wire wr_oe   = reg_wr_i && (reg_addr_i == PSH_OFS_OE);
    wire wr_out  = reg_wr_i && (reg_addr_i == PSH_OFS_OUT);

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            mode_q    <= 1'b0;
            sel_q     <= '1;
            ovr_in_q  <= '1;
            ovr_oe_q  <= '0;
            ovr_out_q <= '0;
        end else begin
            if (wr_ctrl) mode_q <= reg_wdata_i[PSH_CTRL_MODE];
            if (wr_sel) sel_q <= reg_wdata_i[2*NUM_PINS-1:0];
            if (wr_in) ovr_in_q <= reg_wdata_i[NUM_PINS-1:0]; // RL9
            if (wr_oe) ovr_oe_q <= reg_wdata_i[NUM_PINS-1:0]; // RL9
            if (wr_out) ovr_out_q <= reg_wdata_i[NUM_PINS-1:0]; // RL9
        end
    end

    // Programming entry and exit
    wire prog_entry = prog_s2_q && (state_q == PSH_ST_FUNC);
    wire prog_exit  = !prog_s2_q && (state_q == PSH_ST_HOLD);

    always_comb begin
        state_d = state_q;
        case (state_q)
            PSH_ST_FUNC:  if (prog_s2_q) state_d = PSH_ST_HOLD;
            PSH_ST_HOLD:  if (!prog_s2_q) state_d = PSH_ST_APPLY;
            PSH_ST_APPLY: state_d = prog_s2_q ? PSH_ST_HOLD : PSH_ST_FUNC;
            default:      state_d = PSH_ST_FUNC;
        endcase
    end

    // Simple mode cells per pin
    logic [NUM_PINS-1:0] dec_in;
    logic [NUM_PINS-1:0] dec_oe;
    logic [NUM_PINS-1:0] dec_out;

    always_comb begin
        logic [2:0] c;
        c = PSH_CELLS_RST;
        for (int i = 0; i < NUM_PINS; i++) begin
            c          = sel_cells(sel_q[2*i +: 2], last_q[i]); // RL3 RL4 RL5 RL10
            dec_in[i]  = c[PSH_CELL_IN];
            dec_oe[i]  = c[PSH_CELL_OE];
            dec_out[i] = c[PSH_CELL_OUT];
        end
    end

    // Cells to load: override mode bypasses the decode
    wire [NUM_PINS-1:0] load_in  = mode_q ? ovr_in_q : dec_in; // RL9
    wire [NUM_PINS-1:0] load_oe  = mode_q ? ovr_oe_q : dec_oe; // RL9
    wire [NUM_PINS-1:0] load_out = mode_q ? ovr_out_q : dec_out; // RL9

    // Last driven level tracks the functional output until entry
    wire [NUM_PINS-1:0] last_d = func_out_i;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state_q    <= PSH_ST_FUNC;
            last_q     <= '0;
            cell_in_q  <= {NUM_PINS{PSH_CELLS_RST[PSH_CELL_IN]}};
            cell_oe_q  <= {NUM_PINS{PSH_CELLS_RST[PSH_CELL_OE]}};
            cell_out_q <= {NUM_PINS{PSH_CELLS_RST[PSH_CELL_OUT]}};
        end else begin
            state_q <= state_d;
            if (state_q == PSH_ST_FUNC) last_q <= last_d; // RL5
            if (prog_entry || prog_exit) begin
                cell_in_q  <= load_in; // RL1 RL2 RL11
                cell_oe_q  <= load_oe; // RL1 RL2 RL11
                cell_out_q <= load_out; // RL1 RL2 RL11
            end
        end
    end

    // Pin drive: cells while holding, otherwise functional logic (synchronised pad_in_i for pad_in_o)
    wire                holding = (state_q != PSH_ST_FUNC);
    wire [NUM_PINS-1:0] drv_oe  = holding ? cell_oe_q : func_oe_i; // RL6 RL12
    wire [NUM_PINS-1:0] drv_out = holding ? (cell_out_q & cell_oe_q)
                                          : func_out_i; // RL7 RL8 RL12
    wire [NUM_PINS-1:0] drv_in  = holding ? cell_in_q : pin_s2_q;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            pad_oe_o  <= '0;
            pad_out_o <= {NUM_PINS{PSH_PIN_RST}};
            pad_in_o  <= '0;
            holding_o <= 1'b0;
        end else begin
            pad_oe_o  <= drv_oe; // RL6
            pad_out_o <= drv_out; // RL7
            pad_in_o  <= drv_in;
            holding_o <= holding; // RL2
        end
    end

    // Register read data
    logic [31:0] rd_d;
    always_comb begin
        rd_d = '0;
        case (reg_addr_i)
            PSH_OFS_CTRL: rd_d[PSH_CTRL_MODE] = mode_q;
            PSH_OFS_SEL:  rd_d[2*NUM_PINS-1:0] = sel_q;
            PSH_OFS_IN:   rd_d[NUM_PINS-1:0] = ovr_in_q;
            PSH_OFS_OE:   rd_d[NUM_PINS-1:0] = ovr_oe_q;
            PSH_OFS_OUT:  rd_d[NUM_PINS-1:0] = ovr_out_q;
            PSH_OFS_STAT: rd_d[2:0] = state_q;
            PSH_OFS_LAST: rd_d[NUM_PINS-1:0] = last_q;
            default:      rd_d = '0;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) reg_rdata_o <= '0;
        else reg_rdata_o <= reg_rd_i ? rd_d : '0;
    end
endmodule

// ### verification/psh_checker.sv
// Port assertions for the pin state hold block
module psh_checker #(
    parameter int unsigned NUM_PINS = 8
) (
    input wire logic                ref_clk_i,
    input wire logic                rstn_i,
    input wire logic                prog_mode_i,
    input wire logic                reg_rd_i,
    input wire logic [NUM_PINS-1:0] func_out_i,
    input wire logic [NUM_PINS-1:0] func_oe_i,
    input wire logic [31:0]         reg_rdata_o,
    input wire logic [NUM_PINS-1:0] pad_out_o,
    input wire logic [NUM_PINS-1:0] pad_oe_o,
    input wire logic                holding_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    property p_tri; holding_o |-> (pad_out_o & ~pad_oe_o) == '0; endproperty
    a_tri: assert property (p_tri) else $error("undriven pin shows a level");
    property p_enter; $rose(prog_mode_i) |-> ##[3:5] holding_o; endproperty
    a_enter: assert property (p_enter) else $error("hold not taken");
    property p_cause; $rose(holding_o) |-> $past(prog_mode_i, 2); endproperty
    a_cause: assert property (p_cause) else $error("hold without programming");
    property p_stay;
        holding_o && $past(holding_o) && prog_mode_i && $past(prog_mode_i, 3)
        |-> $stable(pad_out_o) && $stable(pad_oe_o);
    endproperty
    a_stay: assert property (p_stay) else $error("pins moved during hold");
    property p_exit; $fell(prog_mode_i) |-> ##[4:7] !holding_o; endproperty
    a_exit: assert property (p_exit) else $error("hold not released");
    property p_fell; $fell(holding_o) |-> !$past(prog_mode_i, 4); endproperty
    a_fell: assert property (p_fell) else $error("hold dropped early");
    property p_func;
        $past(rstn_i) && !holding_o && !$past(holding_o)
        |-> pad_oe_o == $past(func_oe_i) && pad_out_o == $past(func_out_i);
    endproperty
    a_func: assert property (p_func) else $error("pins not functional");
    property p_rd; !$past(reg_rd_i) |-> reg_rdata_o == '0; endproperty
    a_rd: assert property (p_rd) else $error("read data outside its cycle");
    c_enter: cover property ($rose(holding_o));
    c_leave: cover property ($fell(holding_o));
    c_read: cover property (reg_rd_i);
endmodule
bind psh_top psh_checker #(.NUM_PINS(NUM_PINS)) u_chk (.*);

// ### verification/psh_prog_model.sv
// Programmer model holding programming mode for a set time
module psh_prog_model (
    input  wire logic       ref_clk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] len_i,
    output logic            prog_mode_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q = 8'h00;
    always_ff @(posedge ref_clk_i) begin
        cnt_q <= go_i ? len_i : cnt_q - 8'(cnt_q != 8'h00);
    end
    assign prog_mode_o = cnt_q != 8'h00;
endmodule

// ### verification/psh_top_tb.sv
// Testbench for the pin state hold block
module psh_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import psh_pkg::*;
    logic       clk, rstn, go, wr, rd, prog, hold;
    logic [7:0] fo, foe, pin, pout, poe, pino;
    logic [3:0] addr;
    logic [31:0] wd, rdat;
    int         error_cnt, checks;
    logic [33:0] rows[4] = '{{PSH_SEL_LOW, 8'hA5, 8'h00, 8'hFF, 8'hFF},
        {PSH_SEL_HIGH, 8'hA5, 8'hFF, 8'hFF, 8'h00},
        {PSH_SEL_TRI, 8'hA5, 8'h00, 8'h00, 8'hFF},
        {PSH_SEL_HOLD, 8'h3C, 8'h3C, 8'hFF, 8'h3C}};
    psh_prog_model u_prog (.ref_clk_i(clk), .go_i(go), .len_i(8'h14), .prog_mode_o(prog));
    psh_top dut (.ref_clk_i(clk), .rstn_i(rstn), .prog_mode_i(prog), .func_out_i(fo),
        .func_oe_i(foe), .pad_in_i(pin), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .pad_out_o(pout),
        .pad_oe_o(poe), .pad_in_o(pino), .holding_o(hold));
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", rdat, exp);
    endtask
    task automatic wait_hold(input logic v);
        for (int i = 0; i < 40 && hold !== v; i++) tick();
        chk("holding", 32'(hold), 32'(v));
        if (hold !== v) tally_and_finish();
    endtask
    task automatic wait_pads(input logic [7:0] o, e);
        for (int i = 0; i < 40 && !(pout === o && poe === e); i++) tick();
        chk("pad_out", 32'(pout), 32'(o));
        chk("pad_oe", 32'(poe), 32'(e));
    endtask
    task automatic prg;
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        {rstn, go, wr, rd, addr, wd} = '0;
        {fo, foe, error_cnt, checks} = '0;
        pin = 8'h69;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(PSH_OFS_SEL, 32'hFFFF);
        rd_chk(PSH_OFS_STAT, 32'h1);
        rd_chk(PSH_OFS_IN, 32'hFF);
        rd_chk(4'hF, 32'h0);
        chk("pad_in", 32'(pino), 32'h69);
        foreach (rows[i]) begin
            wr_reg(PSH_OFS_SEL, {16'h0, {8{rows[i][33:32]}}});
            fo <= rows[i][31:24];
            prg();
            wait_hold(1'b1);
            chk("pad_out", 32'(pout), 32'(rows[i][23:16]));
            chk("pad_oe", 32'(poe), 32'(rows[i][15:8]));
            chk("pad_in", 32'(pino), 32'(rows[i][7:0]));
            wait_hold(1'b0);
        end
        rd_chk(PSH_OFS_LAST, 32'h3C);
        wr_reg(PSH_OFS_CTRL, 32'h1);
        wr_reg(PSH_OFS_IN, 32'hFF);
        wr_reg(PSH_OFS_OE, 32'hF0);
        wr_reg(PSH_OFS_OUT, 32'h5A);
        fo <= 8'h00;
        foe <= 8'h0F;
        prg();
        wait_hold(1'b1);
        rd_chk(PSH_OFS_STAT, 32'h2);
        wait_pads(8'h50, 8'hF0);
        wr_reg(PSH_OFS_OUT, 32'hFF);
        tick();
        chk("pad_out", 32'(pout), 32'h50);
        wait_pads(8'hF0, 8'hF0);
        wait_hold(1'b0);
        wait_pads(8'h00, 8'h0F);
        tally_and_finish();
    end
endmodule
